// ---- core/sar_seq_defs.svh ----
`ifndef SAR_SEQ_DEFS_SVH
`define SAR_SEQ_DEFS_SVH
// Notes on behaviour
// - every 12-bit conversion lasts at least eighteen converter clocks, and the converter clock stays at or below 14.5 MHz.
// - the sequencer offers eight input channels, each tied to a fixed converter input pin.
// - a scan steps through the enabled channels on its own with no idle converter clock between them.
// - the channel comes either from the sequencing state machine or from a software-written selection, chosen by configuration.
// - each channel has its own result buffer.
// - each channel has its own programmable sample time.
// - each result is checked against a low and a high limit and an out-of-range interrupt is raised when it falls outside.
// - the out-of-range flag is raised at the end of the offending conversion, not at the end of the scan.
// - the reference is chosen among supply, half supply, the bandgap reference and an external pin.
// - the sample-and-hold acquisition window length is programmable.
// - no conversion runs while the chip is in one of the two deepest low-power modes.
// - the on-chip temperature sensor can be selected as a converter input.

// converter geometry
`define SAR_BITS 12
`define NUM_CH 9
`define TEMP_CH 4'h8

// converter clock derived from the system clock
`define SYS_CLK_KHZ 50000
`define CONV_CLK_MAX_KHZ 14500
`define CONV_DIV ((`SYS_CLK_KHZ + `CONV_CLK_MAX_KHZ - 1) / `CONV_CLK_MAX_KHZ)
`define CONV_CLKS 18

// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_CHEN 8'h04
`define OFF_APER 8'h08
`define OFF_LIMIT 8'h0C
`define OFF_STAT 8'h10
`define OFF_MASK 8'h14
`define OFF_INFO 8'h18
`define REGION_SMP 2'h1
`define REGION_RES 2'h2

// field positions
`define CTRL_EN 0
`define CTRL_FW 1
`define CTRL_CONT 2
`define CTRL_START 3
`define CTRL_REF_LSB 4
`define CTRL_MAN_LSB 8
`define LIM_HI_LSB 16
`define STAT_DONE 0
`define STAT_RANGE 1

// reset values
`define RST_CHEN 9'h001
`define RST_APER 8'h02
`define RST_SMP 8'h04
`define RST_LO 12'h000
`define RST_HI 12'hFFF
`define SAR_MID 12'h800

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- core/sar_seq_pkg.sv ----
`include "sar_seq_defs.svh"
package sar_seq_pkg;
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_ACQ = 2'b01,
      SEQ_CONV = 2'b10
   } seq_state_t;

   typedef enum logic [1:0] {
      REF_VDD = 2'b00,
      REF_VDD_HALF = 2'b01,
      REF_BANDGAP = 2'b10,
      REF_EXT_PIN = 2'b11
   } ref_sel_t;

   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_t;

   typedef struct packed {
      logic [3:0] mux_sel;
      logic temp_en;
      ref_sel_t ref_sel;
      logic sample;
      logic [`SAR_BITS-1:0] dac_code;
      logic busy;
   } adc_ctl_t;

   typedef struct packed {
      seq_state_t st;
      logic [3:0] ch;
      logic [8:0] cnt;
      logic [4:0] bitn;
      logic [`SAR_BITS-1:0] dac;
      logic [`SAR_BITS-1:0] code;
      logic sample;
      logic temp;
      logic busy;
      logic en;
      logic fw;
      logic cont;
      logic start_pend;
      ref_sel_t refsel;
      logic [3:0] man;
      logic [`NUM_CH-1:0] chen;
      logic [7:0] aper;
      logic [`SAR_BITS-1:0] lo;
      logic [`SAR_BITS-1:0] hi;
      logic [1:0] stat;
      logic [1:0] mask;
      logic irq;
      logic [`NUM_CH-1:0][7:0] smp;
      logic [`NUM_CH-1:0][`SAR_BITS-1:0] res;
      logic [`NUM_CH-1:0] rvld;
      logic aw_have;
      logic [7:0] awa;
      logic w_have;
      logic [31:0] wd;
      logic [3:0] ws;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ctrl_state_t;
endpackage : sar_seq_pkg

// ---- core/sar_tick_div.sv ----
`timescale 1ns/1ns
`include "sar_seq_defs.svh"
module sar_tick_div (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   output logic o_tick
);
   logic [2:0] cnt;
   logic [2:0] next_cnt;

   // one pulse every CONV_DIV system clocks
   always_comb begin
      next_cnt = (cnt == 3'(`CONV_DIV - 1)) ? 3'h0 : cnt + 3'h1;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         cnt <= 3'h0;
         o_tick <= 1'b0;
      end else begin
         cnt <= next_cnt;
         o_tick <= (cnt == 3'(`CONV_DIV - 1));
      end
   end
endmodule : sar_tick_div

// ---- core/sar_window_cmp.sv ----
`timescale 1ns/1ns
`include "sar_seq_defs.svh"
module sar_window_cmp (
   input wire logic [`SAR_BITS-1:0] i_code,
   input wire logic [`SAR_BITS-1:0] i_lo,
   input wire logic [`SAR_BITS-1:0] i_hi,
   output logic o_out_of_range
);
   // limits themselves are inside the window
   always_comb begin
      o_out_of_range = (i_code < i_lo) || (i_code > i_hi);
   end
endmodule : sar_window_cmp

// ---- core/sar_seq_ctrl.sv ----
`timescale 1ns/1ns
`include "sar_seq_defs.svh"
module sar_seq_ctrl (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire sar_seq_pkg::axi_req_t i_axi,
   output sar_seq_pkg::axi_rsp_t o_axi,
   input wire logic i_cmp_above,
   input wire logic i_lp_deep,
   output sar_seq_pkg::adc_ctl_t o_adc,
   output logic o_adc_tick,
   output logic o_irq
);
   sar_seq_pkg::ctrl_state_t s;
   sar_seq_pkg::ctrl_state_t n;
   logic tick;
   logic oor;
   logic done;
   logic go;
   logic [3:0] go_ch;
   logic [4:0] nx;
   logic [`SAR_BITS-1:0] trial;
   logic [3:0] idx;
   logic [31:0] wv;
   logic [3:0] ri;
   logic [3:0] wi;

   // converter clock enable, at most 14.5 MHz
   sar_tick_div u_div (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .o_tick(tick)
   );

   // window check on the finished code
   sar_window_cmp u_win (
      .i_code(s.code),
      .i_lo(s.lo),
      .i_hi(s.hi),
      .o_out_of_range(oor)
   );

   // byte-lane merge of a write into the old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b+:8] = d[8*b+:8];
         end
      end
      return r;
   endfunction : merge

   // next enabled channel after cur, with wrap flag on top
   function automatic logic [4:0] next_en(input logic [`NUM_CH-1:0] m, input logic [3:0] cur);
      logic [4:0] r;
      logic found;
      int c;
      r = {1'b0, cur};
      found = 1'b0;
      for (int i = 1; i <= `NUM_CH; i++) begin
         c = (int'(cur) + i) % `NUM_CH;
         if (!found && m[c]) begin
            found = 1'b1;
            r = {(c <= int'(cur)), 4'(c)};
         end
      end
      return r;
   endfunction : next_en

   // address decode
   function automatic logic hit(input logic [7:0] a);
      logic h;
      h = 1'b0;
      if (a[7:6] == `REGION_SMP || a[7:6] == `REGION_RES) begin
         h = (a[5:2] < 4'(`NUM_CH));
      end else begin
         h = (a[7:2] <= `OFF_INFO >> 2);
      end
      return h;
   endfunction : hit

   // register image seen by a read
   function automatic logic [31:0] rd(input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (a[7:6] == `REGION_SMP && a[5:2] < 4'(`NUM_CH)) begin
         r = {24'h00_0000, s.smp[a[5:2]]};
      end else if (a[7:6] == `REGION_RES && a[5:2] < 4'(`NUM_CH)) begin
         r = {s.rvld[a[5:2]], 19'h0_0000, s.res[a[5:2]]};
      end else begin
         case ({a[7:2], 2'h0})
            `OFF_CTRL: r = {20'h0_0000, s.man, 2'h0, s.refsel, 1'b0, s.cont, s.fw, s.en};
            `OFF_CHEN: r = {23'h00_0000, s.chen};
            `OFF_APER: r = {24'h00_0000, s.aper};
            `OFF_LIMIT: r = {4'h0, s.hi, 4'h0, s.lo};
            `OFF_STAT: r = {30'h0000_0000, s.stat};
            `OFF_MASK: r = {30'h0000_0000, s.mask};
            `OFF_INFO: r = {7'h00, s.rvld, 8'h00, s.ch, 3'h0, s.busy};
            default: r = 32'h0000_0000;
         endcase
      end
      return r;
   endfunction : rd

   // state after reset
   function automatic sar_seq_pkg::ctrl_state_t rst_state();
      sar_seq_pkg::ctrl_state_t r;
      r = '0;
      r.st = sar_seq_pkg::SEQ_IDLE;
      r.refsel = sar_seq_pkg::REF_VDD;
      r.chen = `RST_CHEN;
      r.aper = `RST_APER;
      r.lo = `RST_LO;
      r.hi = `RST_HI;
      r.smp = {`NUM_CH{`RST_SMP}};
      r.awready = 1'b1;
      r.wready = 1'b1;
      r.arready = 1'b1;
      return r;
   endfunction : rst_state

   assign done = (s.st == sar_seq_pkg::SEQ_CONV) && tick && (s.bitn == 5'(`CONV_CLKS - 1));

   // bus slave, registers and sequencer
   always_comb begin
      n = s;
      go = 1'b0;
      go_ch = s.ch;
      nx = 5'h00;
      trial = s.dac;
      idx = 4'h0;
      wv = 32'h0000_0000;
      ri = i_axi.araddr[5:2];
      wi = s.awa[5:2];
      // write address and data, either order
      if (i_axi.awvalid && s.awready) begin
         n.aw_have = 1'b1;
         n.awa = i_axi.awaddr;
         n.awready = 1'b0;
      end
      if (i_axi.wvalid && s.wready) begin
         n.w_have = 1'b1;
         n.wd = i_axi.wdata;
         n.ws = i_axi.wstrb;
         n.wready = 1'b0;
      end
      if (s.bvalid && i_axi.bready) begin
         n.bvalid = 1'b0;
         n.awready = 1'b1;
         n.wready = 1'b1;
      end
      // commit a write once both halves are held
      if (s.aw_have && s.w_have && !s.bvalid) begin
         n.aw_have = 1'b0;
         n.w_have = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = hit(s.awa) ? `RESP_OKAY : `RESP_SLVERR;
         wv = merge(rd(s.awa), s.wd, s.ws);
         if (s.awa[7:6] == `REGION_SMP && wi < 4'(`NUM_CH)) begin
            n.smp[wi] = wv[7:0];
         end else if (s.awa[7:6] == 2'h0) begin
            case ({s.awa[5:2], 2'h0})
               `OFF_CTRL: begin
                  n.en = wv[`CTRL_EN];
                  n.fw = wv[`CTRL_FW];
                  n.cont = wv[`CTRL_CONT];
                  n.start_pend = s.start_pend | (s.ws[0] & s.wd[`CTRL_START]);
                  n.refsel = sar_seq_pkg::ref_sel_t'(wv[`CTRL_REF_LSB+:2]);
                  n.man = (wv[`CTRL_MAN_LSB+:4] > `TEMP_CH) ? `TEMP_CH : wv[`CTRL_MAN_LSB+:4];
               end
               `OFF_CHEN: n.chen = wv[`NUM_CH-1:0];
               `OFF_APER: n.aper = wv[7:0];
               `OFF_LIMIT: begin
                  n.lo = wv[`SAR_BITS-1:0];
                  n.hi = wv[`LIM_HI_LSB+:`SAR_BITS];
               end
               `OFF_MASK: n.mask = wv[1:0];
               default: n.mask = s.mask;
            endcase
         end
      end
      // reads; status and result valid clear on read
      if (i_axi.arvalid && s.arready) begin
         n.arready = 1'b0;
         n.rvalid = 1'b1;
         n.rdata = rd(i_axi.araddr);
         n.rresp = hit(i_axi.araddr) ? `RESP_OKAY : `RESP_SLVERR;
         if ({i_axi.araddr[7:2], 2'h0} == `OFF_STAT) begin
            n.stat = 2'h0;
         end
         if (i_axi.araddr[7:6] == `REGION_RES && ri < 4'(`NUM_CH)) begin
            n.rvld[ri] = 1'b0;
         end
      end
      if (s.rvalid && i_axi.rready) begin
         n.rvalid = 1'b0;
         n.arready = 1'b1;
      end
      // sequencer, runs on converter clock enables; sets win over clears
      if (i_lp_deep || !s.en) begin
         n.st = sar_seq_pkg::SEQ_IDLE;
         n.sample = 1'b0;
      end else begin
         unique case (s.st)
            sar_seq_pkg::SEQ_IDLE: begin
               if (tick && (s.start_pend || s.cont)) begin
                  if (s.fw) begin
                     go = 1'b1;
                     go_ch = s.man;
                  end else begin
                     nx = next_en(s.chen, `TEMP_CH);
                     go = |s.chen;
                     go_ch = nx[3:0];
                  end
                  n.start_pend = 1'b0;
               end
            end
            sar_seq_pkg::SEQ_ACQ: begin
               if (tick) begin
                  if (s.cnt == 9'h000) begin
                     n.st = sar_seq_pkg::SEQ_CONV;
                     n.sample = 1'b0;
                     n.dac = `SAR_MID;
                     n.bitn = 5'h00;
                  end else begin
                     n.cnt = s.cnt - 9'h001;
                  end
               end
            end
            sar_seq_pkg::SEQ_CONV: begin
               if (tick) begin
                  n.bitn = s.bitn + 5'h01;
                  // one bit decided per converter clock, then settle to 18
                  if (s.bitn < 5'(`SAR_BITS)) begin
                     idx = 4'(5'(`SAR_BITS - 1) - s.bitn);
                     if (!i_cmp_above) begin
                        trial[idx] = 1'b0;
                     end
                     if (idx != 4'h0) begin
                        trial[idx - 4'h1] = 1'b1;
                     end
                     n.dac = trial;
                     if (s.bitn == 5'(`SAR_BITS - 1)) begin
                        n.code = trial;
                     end
                  end
               end
               if (done) begin
                  n.res[s.ch] = s.code;
                  n.rvld[s.ch] = 1'b1;
                  if (oor) begin
                     n.stat[`STAT_RANGE] = 1'b1;
                  end
                  if (s.fw) begin
                     n.stat[`STAT_DONE] = 1'b1;
                     go = s.cont;
                     go_ch = s.man;
                  end else begin
                     nx = next_en(s.chen, s.ch);
                     if (nx[4]) begin
                        n.stat[`STAT_DONE] = 1'b1;
                     end
                     go = (|s.chen) && (!nx[4] || s.cont);
                     go_ch = nx[3:0];
                  end
                  if (!go) begin
                     n.st = sar_seq_pkg::SEQ_IDLE;
                  end
               end
            end
            default: n.st = sar_seq_pkg::SEQ_IDLE;
         endcase
      end
      // start of acquisition on the chosen channel
      if (go) begin
         n.st = sar_seq_pkg::SEQ_ACQ;
         n.ch = go_ch;
         n.cnt = 9'(s.aper) + 9'(s.smp[go_ch]);
         n.sample = 1'b1;
         n.temp = (go_ch == `TEMP_CH);
      end
      n.busy = (n.st != sar_seq_pkg::SEQ_IDLE);
      n.irq = |(n.stat & n.mask);
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         s <= rst_state();
      end else begin
         s <= n;
      end
   end

   // ports straight from state
   assign o_axi = '{awready: s.awready, wready: s.wready, bvalid: s.bvalid, bresp: s.bresp,
                    arready: s.arready, rvalid: s.rvalid, rdata: s.rdata, rresp: s.rresp};
   assign o_adc = '{mux_sel: s.ch, temp_en: s.temp, ref_sel: s.refsel, sample: s.sample,
                    dac_code: s.dac, busy: s.busy};
   assign o_adc_tick = tick;
   assign o_irq = s.irq;

   // helper: system cycles spent converting
   localparam int CONV_SYS = `CONV_CLKS * `CONV_DIV;
   logic [7:0] conv_cyc;
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || s.st != sar_seq_pkg::SEQ_CONV) begin
         conv_cyc <= 8'h00;
      end else begin
         conv_cyc <= conv_cyc + 8'h01;
      end
   end

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   a_conv_length: assert property (
      ($past(s.st) == sar_seq_pkg::SEQ_CONV && s.st != sar_seq_pkg::SEQ_CONV
       && !$past(i_lp_deep) && $past(s.en)) |-> conv_cyc == 8'(CONV_SYS))
      else $error("conversion did not last eighteen converter clocks");
   a_tick_spacing: assert property (
      o_adc_tick |=> !o_adc_tick [*3] ##1 o_adc_tick)
      else $error("converter clock enable spacing wrong");
   a_mux_range: assert property (
      o_adc.mux_sel <= `TEMP_CH)
      else $error("channel select out of range");
   a_no_idle_gap: assert property (
      (done && s.en && !i_lp_deep && s.cont && |s.chen) |=> s.st == sar_seq_pkg::SEQ_ACQ)
      else $error("idle gap between channels");
   a_fw_channel: assert property (
      (go && s.fw && s.en && !i_lp_deep) |=> o_adc.mux_sel == $past(s.man))
      else $error("firmware channel not followed");
   a_result_store: assert property (
      (done && s.en && !i_lp_deep) |=> s.res[$past(s.ch)] == $past(s.code) && s.rvld[$past(s.ch)])
      else $error("result not stored in channel buffer");
   a_acq_length: assert property (
      (go && s.en && !i_lp_deep) |=> s.cnt == 9'($past(s.aper)) + 9'($past(s.smp[go_ch])))
      else $error("acquisition length wrong");
   a_range_flag: assert property (
      (done && oor && s.en && !i_lp_deep) |=> s.stat[`STAT_RANGE]
                                               && (o_irq || !s.mask[`STAT_RANGE]))
      else $error("out of range not flagged at end of conversion");
   a_limit_equal: assert property (
      (s.code == s.lo || s.code == s.hi) && s.lo <= s.hi |-> !oor)
      else $error("limit value counted as out of range");
   a_lowpower_idle: assert property (
      i_lp_deep |=> s.st == sar_seq_pkg::SEQ_IDLE && !o_adc.sample && !o_adc.busy)
      else $error("converter active in deep low power");
   a_temp_select: assert property (
      (o_adc.busy && o_adc.mux_sel == `TEMP_CH) |-> o_adc.temp_en)
      else $error("temperature input not routed");
endmodule : sar_seq_ctrl

// ---- sim/sar_core_model.sv ----
`timescale 1ns/1ns
`include "sar_seq_defs.svh"
module sar_core_model (
   input wire sar_seq_pkg::adc_ctl_t i_adc,
   input wire logic [`NUM_CH-1:0][`SAR_BITS-1:0] i_level,
   output logic o_cmp_above
);
   // comparator: level on the selected pin against the trial code
   always_comb begin
      if (i_adc.mux_sel > `TEMP_CH) begin
         o_cmp_above = 1'b0; // no pin behind this code
      end else begin
         o_cmp_above = (i_level[i_adc.mux_sel] >= i_adc.dac_code);
      end
   end
endmodule : sar_core_model

// ---- sim/tb_top.sv ----
`timescale 1ns/1ns
`include "sar_seq_defs.svh"
module tb_top;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic i_lp_deep = 1'b0;
   logic cmp_above;
   logic o_adc_tick;
   logic o_irq;
   sar_seq_pkg::axi_req_t axi = '0;
   sar_seq_pkg::axi_rsp_t o_axi;
   sar_seq_pkg::adc_ctl_t o_adc;
   logic [`NUM_CH-1:0][`SAR_BITS-1:0] level = '0;
   logic [31:0] rd;
   logic [1:0] resp;
   int n_fail = 0;
   int compares = 0;
   int tick_gap = 0;
   int acq_n = 0;
   int conv_n = 0;
   int last_acq = 0;
   int busy_fall = 0;
   logic prev_smp = 1'b0;
   logic prev_busy = 1'b0;
   logic irq_busy = 1'b0;
   logic [3:0] seq [$];
   logic [3:0] exp_seq [4] = '{4'h0, 4'h2, 4'h3, 4'h8};

   always #10 i_clk_sys = ~i_clk_sys;

   sar_seq_ctrl u_sar_seq_ctrl (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_axi(axi),
      .o_axi(o_axi), .i_cmp_above(cmp_above), .i_lp_deep(i_lp_deep), .o_adc(o_adc),
      .o_adc_tick(o_adc_tick), .o_irq(o_irq));
   sar_core_model u_sar_core_model (.i_adc(o_adc), .i_level(level), .o_cmp_above(cmp_above));

   task automatic results();
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   task automatic tmo();
      n_fail++;
      results();
   endtask : tmo

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // bus write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      axi <= '{a, 1'b1, d, 4'hF, 1'b1, 1'b1, 8'h00, 1'b0, 1'b0};
      for (int k = 0; k < 200; k++) begin
         @(posedge i_clk_sys);
         if (axi.awvalid && o_axi.awready) axi.awvalid <= 1'b0;
         if (axi.wvalid && o_axi.wready) axi.wvalid <= 1'b0;
         if (o_axi.bvalid) begin
            axi.bready <= 1'b0;
            resp = o_axi.bresp;
            return;
         end
      end
      tmo();
   endtask : wr

   // bus read: data taken at the edge where rvalid is sampled
   task automatic rdr(input logic [7:0] a);
      @(posedge i_clk_sys);
      axi <= '{8'h00, 1'b0, 32'h0, 4'h0, 1'b0, 1'b0, a, 1'b1, 1'b1};
      for (int k = 0; k < 200; k++) begin
         @(posedge i_clk_sys);
         if (axi.arvalid && o_axi.arready) axi.arvalid <= 1'b0;
         if (o_axi.rvalid) begin
            axi.rready <= 1'b0;
            rd = o_axi.rdata;
            resp = o_axi.rresp;
            return;
         end
      end
      tmo();
   endtask : rdr

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      rdr(a);
      chk(rd, exp);
   endtask : rchk

   // poll the info word until the channel's result is valid
   task automatic wait_res(input int ch);
      for (int k = 0; k < 300; k++) begin
         rdr(`OFF_INFO);
         if (rd[16+ch] === 1'b1) return;
      end
      tmo();
   endtask : wait_res

   // firmware-selected single conversion, then result readout
   task automatic fw(input int ch);
      wr(`OFF_CTRL, (32'(ch) << `CTRL_MAN_LSB) | 32'hB);
      wait_res(ch);
      rchk(8'h80 + 8'(4 * ch), 32'h8000_0000 | 32'(level[ch]));
   endtask : fw

   // converter-side monitor: tick spacing, window lengths, channel order
   always @(posedge i_clk_sys) begin
      if (!i_rst) begin
         if (o_adc_tick) begin
            if (tick_gap != 0) chk(tick_gap, 4);
            tick_gap = 1;
            if (o_adc.sample) acq_n++;
            else if (o_adc.busy) conv_n++;
         end else if (tick_gap != 0) begin
            tick_gap++;
         end
         if (o_adc.sample && !prev_smp) begin
            if (conv_n != 0) chk(conv_n, 18);
            conv_n = 0;
            acq_n = 0;
            seq.push_back(o_adc.mux_sel);
            if (o_adc.mux_sel == `TEMP_CH) chk(o_adc.temp_en, 1);
         end
         if (!o_adc.sample && prev_smp) last_acq = acq_n;
         if (!o_adc.busy && prev_busy) begin
            chk(conv_n, 18);
            conv_n = 0;
            busy_fall++;
         end
         if (o_irq && o_adc.busy) irq_busy = 1'b1;
         prev_smp = o_adc.sample;
         prev_busy = o_adc.busy;
      end
   end

   initial begin
      repeat (6) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      level <= {12'h3C4, 12'h801, 12'h7FF, 12'hFFF, 12'h000, 12'hE01, 12'h5A3, 12'hE00, 12'h100};
      // reset values and an unmapped hole
      rchk(`OFF_CTRL, 32'h0);
      rchk(`OFF_CHEN, 32'h1);
      rchk(`OFF_APER, 32'h2);
      rchk(`OFF_LIMIT, 32'h0FFF_0000);
      rchk(`OFF_MASK, 32'h0);
      rchk(8'h48, 32'h4);
      rchk(8'h30, 32'h0);
      chk(resp, `RESP_SLVERR);
      wr(8'h30, 32'hFFFF_FFFF);
      chk(resp, `RESP_SLVERR);
      // every reference code reaches the converter
      for (int r = 0; r < 4; r++) begin
         wr(`OFF_CTRL, 32'(r) << `CTRL_REF_LSB);
         repeat (2) @(posedge i_clk_sys);
         chk(o_adc.ref_sel, r[1:0]);
      end
      // every pin and the sensor by firmware selection, own buffers
      for (int c = 0; c < 9; c++) begin
         fw(c);
         chk(last_acq, 7);
      end
      rchk(8'h80, 32'h100);
      // per-channel sample time and aperture length
      wr(8'h48, 32'h7);
      fw(2);
      chk(last_acq, 10);
      wr(`OFF_APER, 32'h5);
      fw(2);
      chk(last_acq, 13);
      // deep low-power mode holds off a pending start
      @(posedge i_clk_sys);
      i_lp_deep <= 1'b1;
      wr(`OFF_CTRL, 32'h50B);
      repeat (200) @(posedge i_clk_sys);
      chk(o_adc.busy, 0);
      i_lp_deep <= 1'b0;
      wait_res(5);
      chk(rd[24:16], 9'h020);
      // scan with one result past the high limit
      wr(`OFF_LIMIT, 32'h0E00_0100);
      wr(`OFF_MASK, 32'h2);
      wr(`OFF_CHEN, 32'h10D);
      rdr(`OFF_STAT);
      seq.delete();
      irq_busy = 1'b0;
      busy_fall = 0;
      wr(`OFF_CTRL, 32'h9);
      wait_res(8);
      chk(seq.size(), 4);
      chk(busy_fall, 1);
      foreach (exp_seq[i]) chk(seq[i], exp_seq[i]);
      foreach (exp_seq[i]) rchk(8'h80 + 8'(4 * exp_seq[i]), 32'h8000_0000 | 32'(level[exp_seq[i]]));
      chk(irq_busy, 1);
      chk(o_irq, 1);
      rchk(`OFF_STAT, 32'h3);
      repeat (2) @(posedge i_clk_sys);
      chk(o_irq, 0);
      // results equal to either limit stay inside the window
      wr(`OFF_CHEN, 32'h003);
      wr(`OFF_CTRL, 32'h9);
      wait_res(1);
      repeat (8) @(posedge i_clk_sys);
      rchk(`OFF_STAT, 32'h1);
      chk(o_irq, 0);
      // continuous scan wraps with no idle, then stops at the wrap once continuous is cleared
      seq.delete();
      busy_fall = 0;
      wr(`OFF_CTRL, 32'h5);
      repeat (500) @(posedge i_clk_sys);
      chk(busy_fall, 0);
      wr(`OFF_CTRL, 32'h1);
      repeat (300) @(posedge i_clk_sys);
      chk(busy_fall, 1);
      chk(seq.size(), 6);
      foreach (seq[i]) chk(seq[i], 4'(i % 2));
      results();
   end
endmodule : tb_top
